// ===== src/coel_consts.svh
// Offsets, field positions and reset values of the comparator event block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef COEL_CONSTS_SVH
`define COEL_CONSTS_SVH

// Register byte offsets on APB
`define COEL_OFF_CTRL     12'h000
`define COEL_OFF_MSKSRC   12'h004
`define COEL_OFF_MSKGATE  12'h008
`define COEL_OFF_FILT     12'h00c
`define COEL_OFF_STATUS   12'h010
`define COEL_OFF_IRQ      12'h014
`define COEL_OFF_MODE     12'h018

// Control register fields
`define COEL_CTRL_EN      15
`define COEL_CTRL_AMP     10
`define COEL_CTRL_INV     13
`define COEL_CTRL_EVT     9
`define COEL_CTRL_RES     8
`define COEL_CTRL_REF     4
`define COEL_CTRL_EDGE_LO 6
`define COEL_CTRL_CH_LO   0

// Mask gating fields
`define COEL_GATE_POL     15
`define COEL_GATE_FEN     3

// Filter register fields
`define COEL_FILT_DIV_LO  0
`define COEL_FILT_SRC_LO  4

// Status register fields
`define COEL_STAT_IDLE    15

// Reset value and filter run length
`define COEL_RST_WORD     32'h0000_0000
`define COEL_FILT_RUN     3

`endif

// ===== src/coel_pkg.sv
// Types shared by the comparator event block.
// Assumes the constants header sits beside it.
`include "coel_consts.svh"
package coel_pkg;
  typedef enum logic [1:0] {
    COEL_EDGE_NONE,
    COEL_EDGE_RISE,
    COEL_EDGE_FALL,
    COEL_EDGE_BOTH
  } coel_edge_t;
  typedef enum {
    COEL_ARMED,
    COEL_HELD,
    COEL_REARM
  } coel_arm_t;
endpackage

// ===== src/coel_filter.sv
// Three-sample digital filter for one conditioned comparator result.
// Assumes samp_pulse is a one-cycle strobe in the ref_clk domain.
`timescale 1ns/100ps
`default_nettype none
`include "coel_consts.svh"
module coel_filter #(
  parameter int RUN = `COEL_FILT_RUN
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic samp_pulse,
  input  wire logic din,
  output logic      dout
);
  logic [RUN-1:0] hist_r;
  logic [RUN-1:0] hist_nxt;
  logic           out_r;
  logic           out_nxt;

  // Shift in samples; change only after RUN equal ones
  always_comb begin
    hist_nxt = hist_r;
    out_nxt  = out_r;
    if (samp_pulse) begin
      hist_nxt = {hist_r[RUN-2:0], din};
      if (&hist_nxt) out_nxt = 1'b1;
      else if (~|hist_nxt) out_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_r <= '0;
      out_r  <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      out_r  <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule // coel_filter
`default_nettype wire

// ===== src/coel_comparator.sv
// Comparator output conditioning, event and interrupt logic with APB regs.
// Assumes comp_raw and mask/filter sources are synchronous to ref_clk.
//
// Operation
// - Enable bit 15 gates every trigger and interrupt of the comparator.
// - Three mask inputs, each picked by its own 4-bit source field.
// - Selected masks form a blanking signal through an AND-OR network.
// - Blanking is inactive after reset.
// - Mask polarity bit 15 chooses whether high or low is held off.
// - Filter output changes only after three equal consecutive samples.
// - Filter enable bit 3 puts the filter in the event, irq and register-read path, else bypassed; comparator_result stays unfiltered.
// - Filter clock source bits 6:4 and divider bits 2:0.
// - Filter is bypassed after reset.
// - Polarity bit 13 inverts the comparator result.
// - Enable and polarity may be written together; disabled blocks events.
// - Event edge field selects which edge fires trigger and event bit.
// - Control bit 4 selects the reference input source.
// - Control bits 1:0 select the channel input source.
// - Event sets latched bit 9 and blocks further events until cleared.
// - After clearing, one extra cycle passes before rearm.
// - Result and event bits mirror read-only in the status register.
// - Irq flag sets when result differs from its last read value.
// - Irq flag and event bit stay set; writing one simulates an event.
// - Amplifier mode suppresses comparator interrupts.
// - Comparator keeps running in sleep and its interrupt wakes device.
// - In idle, idle stop bit 15 withholds comparator interrupts.
// - Reset clears the control register and disables the comparator.
`timescale 1ns/100ps
`default_nettype none
`include "coel_consts.svh"
module coel_comparator
  import coel_pkg::*;
#(
  parameter int NSRC = 16
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            comp_raw,
  input  wire logic [NSRC-1:0] mask_srcs,
  input  wire logic [7:0]      filt_clk_srcs,
  input  wire logic            idle_mode,
  output logic                 comp_trigger,
  output logic                 comparator_irq_flag,
  output logic                 irq_wake,
  output logic                 comparator_result,
  output logic                 reference_input_select,
  output logic      [1:0]      channel_input_select,
  output logic                 amplifier_mode
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] msrc_r, msrc_nxt;
  logic [15:0] gate_r, gate_nxt;
  logic [15:0] filt_r, filt_nxt;
  logic        idle_stop_r, idle_stop_nxt;
  logic        irq_r, irq_nxt;
  logic        evt_r, evt_nxt;
  logic        lastrd_r, lastrd_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rdy_r, rdy_nxt;
  logic        err_r, err_nxt;
  logic        trig_r, trig_nxt;
  logic        wake_r, wake_nxt;
  coel_arm_t   arm_r, arm_nxt;

  // Conditioning pipeline state
  logic        sync_a_r, sync_b_r;
  logic        pol_r, pol_nxt;
  logic        blank_r, blank_nxt;
  logic        cond_r, cond_nxt;
  logic        prev_r;
  logic [7:0]  div_r, div_nxt;
  logic        fclk_d_r;
  logic        samp_r, samp_nxt;
  logic        filt_out;

  // Field views
  logic        en, inv, fen, mpol, evt_clr, evt_set;
  logic [2:0]  fdiv, fsrc;
  coel_edge_t  edge_sel;
  logic [3:0]  sa, sb, sc;
  logic        ma, mb, mc, wr, rd, acc;
  logic        rise, fall, hit, irq_ok;

  assign en       = ctrl_r[`COEL_CTRL_EN];
  assign inv      = ctrl_r[`COEL_CTRL_INV];
  assign edge_sel = coel_edge_t'(ctrl_r[`COEL_CTRL_EDGE_LO +: 2]);
  assign fen      = gate_r[`COEL_GATE_FEN];
  assign mpol     = gate_r[`COEL_GATE_POL];
  assign fdiv     = filt_r[`COEL_FILT_DIV_LO +: 3];
  assign fsrc     = filt_r[`COEL_FILT_SRC_LO +: 3];
  assign sa       = msrc_r[3:0];
  assign sb       = msrc_r[7:4];
  assign sc       = msrc_r[11:8];
  assign ma       = mask_srcs[sa];
  assign mb       = mask_srcs[sb];
  assign mc       = mask_srcs[sc];
  assign acc      = psel && penable;
  // Writes commit at the edge where pready is seen high; reads are
  // captured one edge earlier so prdata stands beside pready
  assign wr       = acc && pwrite && rdy_r;
  assign rd       = acc && !pwrite && !rdy_r;

  // ------------------------------------------------------------
  // Result conditioning
  // ------------------------------------------------------------
  // Input synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
    end else begin
      sync_a_r <= comp_raw;
      sync_b_r <= sync_a_r;
    end
  end

  // Polarity, blanking and filter clock divider
  always_comb begin
    pol_nxt = sync_b_r ^ inv;
    // AND-OR network: enables in gate bits 2:0 OR, bits 6:4 AND terms
    blank_nxt = (gate_r[0] & ma) | (gate_r[1] & mb) | (gate_r[2] & mc)
              | (gate_r[4] & gate_r[5] & ma & mb)
              | (gate_r[6] & mc & (ma | mb));
    div_nxt  = div_r + 8'h01;
    samp_nxt = 1'b0;
    // Divided clock source picks an edge of the selected source
    if (filt_clk_srcs[fsrc] && !fclk_d_r) begin
      if (div_r >= ((8'h01 << fdiv) - 8'h01)) begin
        div_nxt  = 8'h00;
        samp_nxt = 1'b1;
      end
    end else begin
      div_nxt = div_r;
    end
  end

  coel_filter #(
    .RUN (`COEL_FILT_RUN)
  ) u_filter (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .samp_pulse (samp_r),
    .din        (cond_nxt),
    .dout       (filt_out)
  );

  // Blanked value holds the deasserted level chosen by mask polarity
  logic blanked;
  assign blanked = blank_r ? mpol : pol_r;

  always_comb begin
    cond_nxt = blanked;
  end

  logic final_out;
  assign final_out = fen ? filt_out : cond_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_r    <= 1'b0;
      blank_r  <= 1'b0;
      cond_r   <= 1'b0;
      prev_r   <= 1'b0;
      div_r    <= 8'h00;
      fclk_d_r <= 1'b0;
      samp_r   <= 1'b0;
    end else begin
      pol_r    <= pol_nxt;
      blank_r  <= blank_nxt;
      cond_r   <= cond_nxt;
      prev_r   <= final_out;
      div_r    <= div_nxt;
      fclk_d_r <= filt_clk_srcs[fsrc];
      samp_r   <= samp_nxt;
    end
  end

  // ------------------------------------------------------------
  // Event detection and registers
  // ------------------------------------------------------------
  assign rise = final_out && !prev_r;
  assign fall = !final_out && prev_r;
  // Edge code decode
  always_comb begin
    case (edge_sel)
      COEL_EDGE_RISE: hit = rise;
      COEL_EDGE_FALL: hit = fall;
      COEL_EDGE_BOTH: hit = rise || fall;
      default:        hit = 1'b0;
    endcase
  end

  assign irq_ok = !ctrl_r[`COEL_CTRL_AMP]
               && !(idle_mode && idle_stop_r);
  assign evt_clr = wr && paddr == `COEL_OFF_CTRL
                && !pwdata[`COEL_CTRL_EVT];
  assign evt_set = wr && paddr == `COEL_OFF_CTRL
                && pwdata[`COEL_CTRL_EVT];

  // Register writes, event latch, rearm and bus answer
  always_comb begin
    ctrl_nxt      = ctrl_r;
    msrc_nxt      = msrc_r;
    gate_nxt      = gate_r;
    filt_nxt      = filt_r;
    idle_stop_nxt = idle_stop_r;
    irq_nxt       = irq_r;
    evt_nxt       = evt_r;
    lastrd_nxt    = lastrd_r;
    arm_nxt       = arm_r;
    trig_nxt      = 1'b0;
    rdy_nxt       = acc && !rdy_r;
    err_nxt       = 1'b0;
    rdata_nxt     = rdata_r;
    if (wr) begin
      case (paddr)
        `COEL_OFF_CTRL:    ctrl_nxt = pwdata[15:0];
        `COEL_OFF_MSKSRC:  msrc_nxt = pwdata[15:0];
        `COEL_OFF_MSKGATE: gate_nxt = pwdata[15:0];
        `COEL_OFF_FILT:    filt_nxt = pwdata[15:0];
        `COEL_OFF_STATUS:  idle_stop_nxt = pwdata[`COEL_STAT_IDLE];
        `COEL_OFF_IRQ:     irq_nxt = pwdata[0];
        `COEL_OFF_MODE:    ;
        default:           ;
      endcase
    end
    // Unmapped offsets answer with an error beside pready
    if (acc && !rdy_r) begin
      case (paddr)
        `COEL_OFF_CTRL, `COEL_OFF_MSKSRC, `COEL_OFF_MSKGATE,
        `COEL_OFF_FILT, `COEL_OFF_STATUS, `COEL_OFF_IRQ,
        `COEL_OFF_MODE: err_nxt = 1'b0;
        default:        err_nxt = 1'b1;
      endcase
    end
    // Arm sequencer
    case (arm_r)
      COEL_ARMED: begin
        if (en && hit) begin
          evt_nxt  = 1'b1;
          trig_nxt = 1'b1;
          arm_nxt  = COEL_HELD;
        end
      end
      COEL_HELD: begin
        if (evt_clr) arm_nxt = COEL_REARM;
      end
      COEL_REARM: arm_nxt = COEL_ARMED;
      default:    arm_nxt = COEL_ARMED;
    endcase
    if (evt_set) begin
      evt_nxt = 1'b1;
      arm_nxt = COEL_HELD;
    end else if (evt_clr && !(arm_r == COEL_ARMED && en && hit)) begin
      evt_nxt = 1'b0;
    end
    // Result change against last read value; set wins over clear
    if (en && irq_ok && (final_out != lastrd_r)) irq_nxt = 1'b1;
    if (rd) begin
      case (paddr)
        `COEL_OFF_CTRL: begin
          rdata_nxt  = {16'h0000, ctrl_r[15:10], evt_r, final_out,
                        ctrl_r[7:0]};
          lastrd_nxt = final_out;
        end
        `COEL_OFF_MSKSRC:  rdata_nxt = {16'h0000, msrc_r};
        `COEL_OFF_MSKGATE: rdata_nxt = {16'h0000, gate_r};
        `COEL_OFF_FILT:    rdata_nxt = {16'h0000, filt_r};
        `COEL_OFF_STATUS:  rdata_nxt = {16'h0000, idle_stop_r, 5'h00,
                                        evt_r, 8'h00, final_out};
        `COEL_OFF_IRQ:     rdata_nxt = {31'h0, irq_r};
        `COEL_OFF_MODE:    rdata_nxt = {30'h0, idle_mode, en};
        default: begin
          rdata_nxt = `COEL_RST_WORD;
          err_nxt   = 1'b1;
        end
      endcase
    end
    // Enabled interrupt also raises wake request in sleep
    wake_nxt = irq_nxt && en && irq_ok;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r      <= 16'h0000;
      msrc_r      <= 16'h0000;
      gate_r      <= 16'h0000;
      filt_r      <= 16'h0000;
      idle_stop_r <= 1'b0;
      irq_r       <= 1'b0;
      evt_r       <= 1'b0;
      lastrd_r    <= 1'b0;
      arm_r       <= COEL_ARMED;
      trig_r      <= 1'b0;
      wake_r      <= 1'b0;
      rdy_r       <= 1'b0;
      err_r       <= 1'b0;
      rdata_r     <= `COEL_RST_WORD;
    end else begin
      ctrl_r      <= ctrl_nxt;
      msrc_r      <= msrc_nxt;
      gate_r      <= gate_nxt;
      filt_r      <= filt_nxt;
      idle_stop_r <= idle_stop_nxt;
      irq_r       <= irq_nxt;
      evt_r       <= evt_nxt;
      lastrd_r    <= lastrd_nxt;
      arm_r       <= arm_nxt;
      trig_r      <= trig_nxt;
      wake_r      <= wake_nxt;
      rdy_r       <= rdy_nxt;
      err_r       <= err_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata                 = rdata_r;
  assign pready                 = rdy_r;
  assign pslverr                = err_r;
  assign comp_trigger           = trig_r;
  assign comparator_irq_flag    = irq_r;
  assign irq_wake               = wake_r;
  assign comparator_result      = cond_r;
  assign reference_input_select = ctrl_r[`COEL_CTRL_REF];
  assign channel_input_select   = ctrl_r[`COEL_CTRL_CH_LO +: 2];
  assign amplifier_mode         = ctrl_r[`COEL_CTRL_AMP];
endmodule // coel_comparator
`default_nettype wire

// ===== bench/coel_comp_model.sv
// Far-side stand-in: analog core result and filter clock sources.
// Assumes the bench drives the wanted comparator level on level.
`timescale 1ns/100ps
`default_nettype none
module coel_comp_model #(
  parameter int DLY = 2
) (
  input  wire logic       ref_clk,
  input  wire logic       level,
  output logic            comp_raw,
  output logic [7:0]      filt_clk_srcs
);
  logic [7:0]   cnt_r = 8'h00;
  logic [DLY:0] dly_r = '0;
  // Response delay of the analog core; sources are binary divisions
  always @(posedge ref_clk) begin
    cnt_r <= cnt_r + 8'h01;
    dly_r <= {dly_r[DLY-1:0], level};
  end
  assign comp_raw      = dly_r[DLY];
  assign filt_clk_srcs = cnt_r;
endmodule // coel_comp_model
`default_nettype wire

// ===== bench/coel_comparator_chk.sv
// Port-level timing checks for the comparator event block.
// Assumes it is bound to coel_comparator and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "coel_consts.svh"
module coel_comparator_chk #(
  parameter int NSRC = 16
) (
  input wire logic            ref_clk,
  input wire logic            rst_b,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            comp_raw,
  input wire logic [NSRC-1:0] mask_srcs,
  input wire logic [7:0]      filt_clk_srcs,
  input wire logic            idle_mode,
  input wire logic            comp_trigger,
  input wire logic            comparator_irq_flag,
  input wire logic            irq_wake,
  input wire logic            comparator_result,
  input wire logic            reference_input_select,
  input wire logic [1:0]      channel_input_select,
  input wire logic            amplifier_mode
);
  logic wr, en_r, en_nxt, stop_r, stop_nxt;
  // Shadow of enable and idle stop, taken from completed writes
  assign wr = psel && penable && pready && pwrite;
  always_comb begin
    en_nxt = en_r;
    stop_nxt = stop_r;
    if (wr && paddr == `COEL_OFF_CTRL)
      en_nxt = pwdata[`COEL_CTRL_EN];
    if (wr && paddr == `COEL_OFF_STATUS)
      stop_nxt = pwdata[`COEL_STAT_IDLE];
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      stop_r <= stop_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_late: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not two cycles");
  a_bad_addr: assert property (pready && paddr > `COEL_OFF_MODE |-> pslverr)
    else $error("unmapped access without error");
  a_trig_single: assert property (comp_trigger |=> !comp_trigger)
    else $error("trigger not blocked after event");
  a_trig_gated: assert property (
    comp_trigger |-> en_r || $past(en_r))
    else $error("trigger while disabled");
  a_wake_gated: assert property (
    irq_wake |-> en_r || $past(en_r))
    else $error("wake while disabled");
  a_flag_sticky: assert property (comparator_irq_flag &&
    !(wr && paddr == `COEL_OFF_IRQ) |=> comparator_irq_flag)
    else $error("irq flag dropped without a write");
  a_idle_hold: assert property (idle_mode && stop_r &&
    $past(idle_mode) && $past(stop_r) |-> !irq_wake)
    else $error("interrupt in idle with stop set");
  a_amp_quiet: assert property (amplifier_mode &&
    $past(amplifier_mode) |-> !irq_wake)
    else $error("interrupt in amplifier mode");
  a_sel_follow: assert property (wr && paddr == `COEL_OFF_CTRL |=>
    channel_input_select == $past(pwdata[1:0]) &&
    reference_input_select == $past(pwdata[4]))
    else $error("input selects not taken from write");
  c_trig: cover property (comp_trigger);
  c_err: cover property (pready && pslverr);
  c_idle: cover property (idle_mode && comparator_irq_flag && !irq_wake);
endmodule // coel_comparator_chk
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the comparator event block.
// Assumes the design, its package and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk = 1'b0, rst_b = 1'b0, idle_mode = 1'b0, lvl = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] mask_srcs = 16'h0000;
  logic [7:0]  filt_clk_srcs;
  logic [1:0]  chs;
  logic        pready, pslverr, perr, comp_raw, trig, flag, wake, res, rs, amp;
  int          failures = 0, n_tests = 0, ntrig = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (trig === 1'b1) ntrig <= ntrig + 1;
  coel_comp_model mdl_u (.ref_clk(ref_clk), .level(lvl),
    .comp_raw(comp_raw), .filt_clk_srcs(filt_clk_srcs));
  coel_comparator dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_raw(comp_raw), .mask_srcs(mask_srcs),
    .filt_clk_srcs(filt_clk_srcs), .idle_mode(idle_mode),
    .comp_trigger(trig), .comparator_irq_flag(flag), .irq_wake(wake),
    .comparator_result(res), .reference_input_select(rs),
    .channel_input_select(chs), .amplifier_mode(amp));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    perr = pslverr;
    if (k >= 20) begin
      failures++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk({perr, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h000, 32'h0000_0013);
    chk({rs, chs}, 3'b111);
  endtask
  // Each edge code, then the both-edges code with enable off
  task automatic t_edge;
    int b;
    logic [31:0] c;
    for (int e = 0; e < 5; e++) begin
      c = (e < 4) ? 32'h8000 | (e << 6) : 32'h00c0;
      lvl <= 1'b0;
      cyc(10);
      apb(1'b1, 12'h000, c);
      b = ntrig;
      lvl <= 1'b1;
      cyc(12);
      chk(ntrig - b, e == 1 || e == 3);
      apb(1'b1, 12'h000, c);
      b = ntrig;
      lvl <= 1'b0;
      cyc(12);
      chk(ntrig - b, e == 2 || e == 3);
    end
  endtask
  task automatic t_block;
    int b;
    apb(1'b1, 12'h000, 32'h8040);
    b = ntrig;
    lvl <= 1'b1;
    cyc(12);
    lvl <= 1'b0;
    cyc(10);
    lvl <= 1'b1;
    cyc(12);
    chk(ntrig - b, 1);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd & 32'h0201, 32'h0201);
    apb(1'b1, 12'h000, 32'h8040);
    lvl <= 1'b0;
    cyc(10);
    lvl <= 1'b1;
    cyc(12);
    chk(ntrig - b, 2);
    apb(1'b1, 12'h000, 32'ha000);
    cyc(10);
    chk(res, 1'b0);
    lvl <= 1'b0;
    cyc(10);
    chk(res, 1'b1);
  endtask
  // Mask gate, mask lines, level, expected result
  task automatic t_blank;
    logic [15:0] g[6] = '{16'h1, 16'h1, 16'h4, 16'h30, 16'h30, 16'h8001};
    logic [15:0] m[6] = '{16'h20, 16'h0, 16'h80, 16'h20, 16'h60, 16'h20};
    logic [5:0] lv = 6'b011111;
    logic [5:0] ex = 6'b101010;
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b1, 12'h004, 32'h0765);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h008, {16'h0, g[i]});
      mask_srcs <= m[i];
      lvl <= lv[i];
      cyc(10);
      chk(res, ex[i]);
    end
    apb(1'b1, 12'h008, 32'h0);
    mask_srcs <= 16'h0;
    lvl <= 1'b0;
    cyc(10);
  endtask
  task automatic t_filter;
    int b;
    apb(1'b1, 12'h008, 32'h0008);
    apb(1'b1, 12'h00c, 32'h0022);
    apb(1'b1, 12'h000, 32'h8040);
    cyc(150);
    b = ntrig;
    lvl <= 1'b1;
    cyc(10);
    lvl <= 1'b0;
    cyc(150);
    chk(ntrig - b, 0);
    lvl <= 1'b1;
    cyc(200);
    chk(ntrig - b, 1);
    apb(1'b1, 12'h008, 32'h0);
    lvl <= 1'b0;
    cyc(10);
  endtask
  task automatic t_irq;
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    cyc(3);
    chk(flag, 1'b0);
    lvl <= 1'b1;
    cyc(30);
    chk({flag, wake}, 2'b11);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'hff00, 32'h8100);
    apb(1'b1, 12'h014, 32'h0);
    cyc(3);
    chk(flag, 1'b0);
    apb(1'b1, 12'h014, 32'h1);
    cyc(3);
    chk(flag, 1'b1);
    apb(1'b1, 12'h010, 32'h8000);
    idle_mode <= 1'b1;
    cyc(3);
    chk(wake, 1'b0);
    idle_mode <= 1'b0;
    cyc(3);
    chk(wake, 1'b1);
    apb(1'b1, 12'h000, 32'h8400);
    cyc(3);
    chk({amp, wake}, 2'b10);
    apb(1'b0, 12'h018, 32'h0);
    chk({perr, rd[30:0]}, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h8200);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'h0200, 32'h0200);
  endtask
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    cyc(1);
    t_reset;
    t_edge;
    t_block;
    t_blank;
    t_filter;
    t_irq;
    tally_and_finish;
  end
  initial begin
    cyc(40000);
    failures++;
    tally_and_finish;
  end
endmodule // tb
bind coel_comparator coel_comparator_chk #(.NSRC(NSRC)) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw),
  .mask_srcs(mask_srcs), .filt_clk_srcs(filt_clk_srcs),
  .idle_mode(idle_mode), .comp_trigger(comp_trigger),
  .comparator_irq_flag(comparator_irq_flag), .irq_wake(irq_wake),
  .comparator_result(comparator_result),
  .reference_input_select(reference_input_select),
  .channel_input_select(channel_input_select),
  .amplifier_mode(amplifier_mode));
`default_nettype wire
